// >>> hw/rdio_pkg.sv
package rdio_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int N_IN = 10;
  localparam int N_OUT = 16;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_POWER = 12'h008;
  localparam logic [11:0] ADDR_PRESET = 12'h00c;
  localparam logic [11:0] ADDR_INCFG = 12'h040;
  localparam logic [11:0] ADDR_OUTCFG = 12'h080;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int CFG_FN_LSB = 0;
  localparam int CFG_POL_LSB = 4;
  localparam int CFG_ARG_LSB = 8;
  localparam int OCFG_SRC_LSB = 0;
  localparam int OCFG_ARG_LSB = 4;
  localparam int OCFG_INV_BIT = 8;
  localparam int ST_RF_BIT = 16;
  localparam int ST_EXC_BIT = 17;
  localparam int ST_AUTO_BIT = 18;
  localparam int ST_RFEN_BIT = 19;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [6:0] POWER_RST = 7'h64;
  localparam logic [6:0] POWER_MAX = 7'h64;
  localparam logic [6:0] POWER_STEP = 7'h01;
  localparam logic [3:0] PRESET_RST = 4'h0;
  localparam logic [11:0] INCFG_RST = 12'h000;
  localparam logic [8:0] OUTCFG_RST = 9'h000;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int FILT_NS = 1000;
  localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int HOST_RST_NS = 10000;
  localparam int HOST_RST_CYC = (HOST_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int HALF_SEC_MS = 500;
  localparam int HALF_SEC_CYC = HALF_SEC_MS * CLK_MHZ * 1000;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    FN_NONE = 4'h0, FN_RF = 4'h1, FN_RESET = 4'h2, FN_REBOOT = 4'h3,
    FN_EXCITER = 4'h4, FN_AUTO = 4'h5, FN_POWER = 4'h6, FN_PRESET = 4'h7
  } rdio_fn_e;

  typedef enum logic [3:0] {
    POL_RISE_ON = 4'h0, POL_FALL_ON = 4'h1, POL_RISE_OFF = 4'h2,
    POL_FALL_OFF = 4'h3, POL_FALL_TOG = 4'h4, POL_RISE_TOG = 4'h5,
    POL_RON_FOFF = 4'h6, POL_FON_ROFF = 4'h7, POL_HI_INC = 4'h8,
    POL_LO_INC = 4'h9, POL_HI_DEC = 4'ha, POL_LO_DEC = 4'hb
  } rdio_pol_e;

  typedef enum logic [3:0] {
    SRC_NONE = 4'h0, SRC_REMOTE = 4'h1, SRC_RF = 4'h2, SRC_PRESET = 4'h3,
    SRC_EXCITER = 4'h4, SRC_AUTO = 4'h5, SRC_ALARM = 4'h6, SRC_AUDIO = 4'h7
  } rdio_src_e;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b01, APB_ACK = 2'b10
  } rdio_apb_e;

endpackage

// >>> hw/rdio_mapper.sv
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/100ps
// How it works
// - Ten inputs, each mapped to one function
// - Inputs ignored unless remote control enabled
// - Unassigned input has no effect at all
// - RF input issues RF on/off requests
// - Reset input requests full system reset
// - Reboot input pulses host console reset
// - Exciter input selects exciter A or B
// - Toggle activations invert auto changeover enable
// - Power step changes level by one percent
// - Held power input repeats every half second
// - Lowest active power input index wins
// - Preset input makes its preset active
// - Turn-on polarity activates on chosen edge
// - Turn-off polarity deactivates on chosen edge
// - Toggle polarity alternates on successive edges
// - Combined polarity: one edge on, other off
// - Level polarities drive power and preset
// - Sixteen outputs, each one source or none
// - Remote-enabled output low while remote
// - Preset/exciter outputs low or released
// - Alarm and audio outputs show their source
// - Each output with a source has its sense selectable by invert bit
module rdio_mapper #(
  parameter int REPEAT_CYC = rdio_pkg::HALF_SEC_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [9:0] remote_in,
  input wire logic rf_stage_on,
  input wire logic [15:0] alarm,
  input wire logic [3:0] audio_active,
  output logic rf_on_req,
  output logic rf_off_req,
  output logic sys_reset_req,
  output logic host_reset,
  output logic remote_enabled,
  output logic exciter_b,
  output logic auto_changeover,
  output logic [6:0] power_level,
  output logic [3:0] preset_active,
  output logic [15:0] rout_o,
  output logic [15:0] rout_oe
);

  typedef struct packed {
    rdio_pkg::rdio_apb_e ap;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic remote;
    logic [6:0] power;
    logic [3:0] preset;
    logic exciter_b;
    logic auto_co;
    logic rf_en;
    logic [9:0][11:0] incfg;
    logic [15:0][8:0] outcfg;
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic [9:0] filt;
    logic [9:0] filtp;
    logic [9:0] tog;
    logic [9:0][7:0] fcnt;
    logic [26:0] rep_cnt;
    logic [3:0] rep_idx;
    logic rep_act;
    logic rep_dir;
    logic rf_on_req;
    logic rf_off_req;
    logic sys_reset_req;
    logic host_reset;
    logic [10:0] host_cnt;
    logic [15:0] dout_o;
    logic [15:0] dout_oe;
  } rdio_state_s;

  rdio_state_s s;
  rdio_state_s next_s;

  // Selected-edge sense of a polarity: high when the input is "asserted"
  function automatic logic pol_act(input logic [3:0] pol, input logic x);
    unique case (pol)
      rdio_pkg::POL_RISE_ON, rdio_pkg::POL_RISE_OFF, rdio_pkg::POL_RISE_TOG,
      rdio_pkg::POL_RON_FOFF, rdio_pkg::POL_HI_INC, rdio_pkg::POL_HI_DEC:
        pol_act = x;
      default:
        pol_act = ~x;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [3:0] fn;
    logic [3:0] pol;
    logic [3:0] arg;
    logic a_now;
    logic a_old;
    logic edge_sel;
    logic on_ev;
    logic off_ev;
    logic is_fall;
    logic win;
    logic [3:0] widx;
    logic wdir;
    logic step;
    logic cond;
    logic low;
    logic [3:0] idx;
    fn = 4'h0;
    pol = 4'h0;
    arg = 4'h0;
    a_now = 1'b0;
    a_old = 1'b0;
    edge_sel = 1'b0;
    on_ev = 1'b0;
    off_ev = 1'b0;
    is_fall = 1'b0;
    win = 1'b0;
    widx = 4'h0;
    wdir = 1'b0;
    step = 1'b0;
    cond = 1'b0;
    low = 1'b0;
    idx = 4'h0;
    next_s = s;
    next_s.rf_on_req = 1'b0;
    next_s.rf_off_req = 1'b0;
    next_s.sys_reset_req = 1'b0;

    // APB slave: answer registered in the first access cycle
    unique case (s.ap)
      rdio_pkg::APB_IDLE: begin
        if (psel && !penable) begin
          next_s.ap = rdio_pkg::APB_ACK;
          next_s.pready = 1'b1;
          next_s.pslverr = 1'b0;
          next_s.prdata = 32'h0000_0000;
          idx = paddr[5:2];
          if (paddr == rdio_pkg::ADDR_CTRL) begin
            next_s.prdata[0] = s.remote;
          end else if (paddr == rdio_pkg::ADDR_STATUS) begin
            next_s.prdata[9:0] = s.filt;
            next_s.prdata[rdio_pkg::ST_RF_BIT] = rf_stage_on;
            next_s.prdata[rdio_pkg::ST_EXC_BIT] = s.exciter_b;
            next_s.prdata[rdio_pkg::ST_AUTO_BIT] = s.auto_co;
            next_s.prdata[rdio_pkg::ST_RFEN_BIT] = s.rf_en;
          end else if (paddr == rdio_pkg::ADDR_POWER) begin
            next_s.prdata[6:0] = s.power;
          end else if (paddr == rdio_pkg::ADDR_PRESET) begin
            next_s.prdata[3:0] = s.preset;
          end else if (paddr[11:6] == rdio_pkg::ADDR_INCFG[11:6] &&
                       paddr[1:0] == 2'b00 && idx < 4'ha) begin
            next_s.prdata[11:0] = s.incfg[idx];
          end else if (paddr[11:6] == rdio_pkg::ADDR_OUTCFG[11:6] &&
                       paddr[1:0] == 2'b00) begin
            next_s.prdata[8:0] = s.outcfg[idx];
          end else begin
            next_s.pslverr = 1'b1;
          end
        end
      end
      rdio_pkg::APB_ACK: begin
        next_s.ap = rdio_pkg::APB_IDLE;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        idx = paddr[5:2];
        if (psel && penable && pwrite && !s.pslverr) begin
          if (paddr == rdio_pkg::ADDR_CTRL) begin
            next_s.remote = pwdata[0];
          end else if (paddr == rdio_pkg::ADDR_POWER) begin
            next_s.power = (pwdata[6:0] > rdio_pkg::POWER_MAX) ?
                           rdio_pkg::POWER_MAX : pwdata[6:0];
          end else if (paddr == rdio_pkg::ADDR_PRESET) begin
            next_s.preset = pwdata[3:0];
          end else if (paddr[11:6] == rdio_pkg::ADDR_INCFG[11:6]) begin
            next_s.incfg[idx] = pwdata[11:0];
          end else if (paddr[11:6] == rdio_pkg::ADDR_OUTCFG[11:6]) begin
            next_s.outcfg[idx] = pwdata[8:0];
          end
        end
      end
    endcase

    next_s.sync1 = remote_in;
    next_s.sync2 = s.sync1;
    next_s.filtp = s.filt;
    for (int i = 0; i < rdio_pkg::N_IN; i++) begin
      if (s.sync2[i] == s.filt[i]) begin
        next_s.fcnt[i] = 8'h00;
      end else if (s.fcnt[i] == 8'(rdio_pkg::FILT_CYC - 1)) begin
        next_s.fcnt[i] = 8'h00;
        next_s.filt[i] = s.sync2[i];
      end else begin
        next_s.fcnt[i] = s.fcnt[i] + 8'h01;
      end
    end

    // Per-input event decode; descending loop so the lowest index wins
    for (int i = rdio_pkg::N_IN - 1; i >= 0; i--) begin
      fn = s.incfg[i][rdio_pkg::CFG_FN_LSB +: 4];
      pol = s.incfg[i][rdio_pkg::CFG_POL_LSB +: 4];
      arg = s.incfg[i][rdio_pkg::CFG_ARG_LSB +: 4];
      a_now = pol_act(pol, s.filt[i]);
      a_old = pol_act(pol, s.filtp[i]);
      edge_sel = a_now & ~a_old;
      is_fall = (pol == rdio_pkg::POL_FALL_TOG);
      on_ev = 1'b0;
      off_ev = 1'b0;
      unique case (pol)
        rdio_pkg::POL_RISE_OFF, rdio_pkg::POL_FALL_OFF: begin
          off_ev = edge_sel;
        end
        // toggle: falling variant starts by deactivating
        rdio_pkg::POL_FALL_TOG, rdio_pkg::POL_RISE_TOG: begin
          on_ev = edge_sel & (s.tog[i] == is_fall);
          off_ev = edge_sel & (s.tog[i] != is_fall);
        end
        rdio_pkg::POL_RON_FOFF, rdio_pkg::POL_FON_ROFF: begin
          on_ev = edge_sel;
          off_ev = a_old & ~a_now;
        end
        // turn-on and level polarities start on the selected edge
        default: begin
          on_ev = edge_sel;
        end
      endcase
      // remote gating, unassigned inputs do nothing
      if (!s.remote || fn == rdio_pkg::FN_NONE) begin
        on_ev = 1'b0;
        off_ev = 1'b0;
      end else if (edge_sel && (pol == rdio_pkg::POL_FALL_TOG ||
                                pol == rdio_pkg::POL_RISE_TOG)) begin
        next_s.tog[i] = ~s.tog[i];
      end
      unique case (fn)
        rdio_pkg::FN_RF: begin
          if (on_ev) begin
            next_s.rf_on_req = 1'b1;
            next_s.rf_en = 1'b1;
          end
          if (off_ev) begin
            next_s.rf_off_req = 1'b1;
            next_s.rf_en = 1'b0;
          end
        end
        rdio_pkg::FN_RESET: begin
          if (on_ev) begin
            next_s.sys_reset_req = 1'b1;
          end
        end
        rdio_pkg::FN_REBOOT: begin
          if (on_ev) begin
            next_s.host_reset = 1'b1;
            next_s.host_cnt = 11'(rdio_pkg::HOST_RST_CYC - 1);
          end
        end
        rdio_pkg::FN_EXCITER: begin
          if (on_ev) begin
            next_s.exciter_b = arg[0];
          end
        end
        rdio_pkg::FN_AUTO: begin
          // toggle inverts, other polarities set or clear
          if (pol == rdio_pkg::POL_FALL_TOG || pol == rdio_pkg::POL_RISE_TOG) begin
            if (on_ev || off_ev) begin
              next_s.auto_co = ~s.auto_co;
            end
          end else if (on_ev) begin
            next_s.auto_co = 1'b1;
          end else if (off_ev) begin
            next_s.auto_co = 1'b0;
          end
        end
        rdio_pkg::FN_POWER: begin
          // lowest active index; DEC polarities step down, other polarities take direction from arg[0]
          if (s.remote && a_now) begin
            win = 1'b1;
            widx = 4'(i);
            wdir = (pol == rdio_pkg::POL_HI_DEC || pol == rdio_pkg::POL_LO_DEC)
                   ? 1'b1 : arg[0];
          end
        end
        rdio_pkg::FN_PRESET: begin
          if (on_ev) begin
            next_s.preset = arg;
          end
        end
        default: begin
        end
      endcase
    end

    if (s.host_reset && next_s.host_cnt == s.host_cnt) begin
      if (s.host_cnt == 11'h000) begin
        next_s.host_reset = 1'b0;
      end else begin
        next_s.host_cnt = s.host_cnt - 11'h001;
      end
    end

    // repeat while held, restart on a change of held input
    if (!win) begin
      next_s.rep_act = 1'b0;
    end else if (!s.rep_act || widx != s.rep_idx || wdir != s.rep_dir) begin
      step = 1'b1;
      next_s.rep_act = 1'b1;
      next_s.rep_idx = widx;
      next_s.rep_dir = wdir;
      next_s.rep_cnt = 27'(REPEAT_CYC - 1);
    end else if (s.rep_cnt == 27'h0) begin
      step = 1'b1;
      next_s.rep_cnt = 27'(REPEAT_CYC - 1);
    end else begin
      next_s.rep_cnt = s.rep_cnt - 27'h1;
    end
    // one percent step, saturating; overrides a same-cycle write
    if (step) begin
      if (!wdir && s.power < rdio_pkg::POWER_MAX) begin
        next_s.power = s.power + rdio_pkg::POWER_STEP;
      end else if (wdir && s.power != 7'h00) begin
        next_s.power = s.power - rdio_pkg::POWER_STEP;
      end else begin
        next_s.power = s.power;
      end
    end

    for (int j = 0; j < rdio_pkg::N_OUT; j++) begin
      arg = s.outcfg[j][rdio_pkg::OCFG_ARG_LSB +: 4];
      unique case (s.outcfg[j][rdio_pkg::OCFG_SRC_LSB +: 4])
        rdio_pkg::SRC_REMOTE: cond = s.remote;
        rdio_pkg::SRC_RF: cond = rf_stage_on;
        rdio_pkg::SRC_PRESET: cond = (s.preset == arg);
        rdio_pkg::SRC_EXCITER: cond = (s.exciter_b == arg[0]);
        rdio_pkg::SRC_AUTO: cond = s.auto_co;
        rdio_pkg::SRC_ALARM: cond = alarm[arg];
        rdio_pkg::SRC_AUDIO: cond = audio_active[arg[1:0]];
        default: cond = 1'b0;
      endcase
      low = cond ^ s.outcfg[j][rdio_pkg::OCFG_INV_BIT];
      unique case (s.outcfg[j][rdio_pkg::OCFG_SRC_LSB +: 4])
        rdio_pkg::SRC_PRESET, rdio_pkg::SRC_EXCITER: begin
          // open collector: pull low or release
          next_s.dout_o[j] = 1'b0;
          next_s.dout_oe[j] = low;
        end
        rdio_pkg::SRC_REMOTE, rdio_pkg::SRC_RF, rdio_pkg::SRC_AUTO,
        rdio_pkg::SRC_ALARM, rdio_pkg::SRC_AUDIO: begin
          next_s.dout_o[j] = ~low;
          next_s.dout_oe[j] = 1'b1;
        end
        default: begin
          next_s.dout_o[j] = 1'b1;
          next_s.dout_oe[j] = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ap <= rdio_pkg::APB_IDLE;
      s.remote <= rdio_pkg::CTRL_RST;
      s.power <= rdio_pkg::POWER_RST;
      s.preset <= rdio_pkg::PRESET_RST;
      s.incfg <= {rdio_pkg::N_IN{rdio_pkg::INCFG_RST}};
      s.outcfg <= {rdio_pkg::N_OUT{rdio_pkg::OUTCFG_RST}};
      s.dout_o <= 16'hffff;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign rf_on_req = s.rf_on_req;
  assign rf_off_req = s.rf_off_req;
  assign sys_reset_req = s.sys_reset_req;
  assign host_reset = s.host_reset;
  assign remote_enabled = s.remote;
  assign exciter_b = s.exciter_b;
  assign auto_changeover = s.auto_co;
  assign power_level = s.power;
  assign preset_active = s.preset;
  assign rout_o = s.dout_o;
  assign rout_oe = s.dout_oe;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic apb_wr;
  assign apb_wr = psel & penable & s.pready & pwrite;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_rf_gated: assert property (
    (s.rf_on_req || s.rf_off_req || s.sys_reset_req) |-> $past(s.remote))
    else $error("action issued while local");
  chk_exciter_src: assert property (
    $changed(s.exciter_b) |-> $past(s.remote))
    else $error("exciter changed without remote input");
  chk_host_len: assert property (
    $rose(s.host_reset) |-> s.host_reset [*8])
    else $error("host reset too short");
  chk_power_step: assert property (
    ($changed(s.power) && !$past(apb_wr)) |->
    (s.power == $past(s.power) + 7'h01 || s.power == $past(s.power) - 7'h01))
    else $error("power moved by more than one step");
  chk_repeat_count: assert property (
    (s.rep_act && $past(s.rep_act) && $past(s.rep_idx) == s.rep_idx &&
     $past(s.rep_dir) == s.rep_dir && $past(s.rep_cnt) != 27'h0) |->
    s.rep_cnt == $past(s.rep_cnt) - 27'h1)
    else $error("repeat counter not counting down");
  chk_remote_out: assert property (
    $past(s.outcfg[0][3:0] == rdio_pkg::SRC_REMOTE && !s.outcfg[0][8]) |->
    (rout_oe[0] && rout_o[0] == !$past(s.remote)))
    else $error("remote status output wrong");
  chk_preset_oc: assert property (
    $past(s.outcfg[0][3:0] == rdio_pkg::SRC_PRESET) |->
    (!rout_o[0] && rout_oe[0] ==
     (($past(s.preset) == $past(s.outcfg[0][7:4])) ^ $past(s.outcfg[0][8]))))
    else $error("preset output not open collector");
  chk_filter_stable: assert property (
    $changed(s.filt[0]) |-> ($past(s.sync2[0], 2) == s.filt[0]))
    else $error("filter passed an unstable level");
  chk_apb_ready: assert property (
    s.pready |=> !s.pready)
    else $error("pready held longer than one cycle");

  cov_rf_on: cover property (s.rf_on_req);
  cov_power_up: cover property (s.rep_act && s.power > $past(s.power));
  cov_host_reset: cover property ($rose(s.host_reset));
  cov_preset: cover property ($changed(s.preset) && !$past(apb_wr));

endmodule

// >>> dv/rdio_remote_unit.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Remote control unit: drives the input lines, reads the pins
// ------------------------------------------------------------
module rdio_remote_unit (
  input wire logic pclk,
  input wire logic [9:0] level_req,
  input wire logic [15:0] rout_o,
  input wire logic [15:0] rout_oe,
  output logic [9:0] remote_in,
  output logic [15:0] pin
);
  initial remote_in = 10'h000;
  // Contacts change only just after a clock edge
  always @(posedge pclk) begin
    remote_in <= level_req;
  end
  // Undriven open-collector lines sit at the pull-up level
  always_comb begin
    for (int j = 0; j < 16; j++) begin
      pin[j] = rout_oe[j] ? rout_o[j] : 1'b1;
    end
  end
endmodule

// >>> dv/remote_discrete_io_mapper_test.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
  num_errors++; $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module remote_discrete_io_mapper_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic [9:0] remote_in, level_req = 10'h000;
  logic rf_stage_on = 1'b0;
  logic [15:0] alarm = 16'h0000, rout_o, rout_oe, pin;
  logic [3:0] audio_active = 4'h0;
  logic rf_on_req, rf_off_req, sys_reset_req, host_reset, remote_enabled;
  logic exciter_b, auto_changeover;
  logic [6:0] power_level, pw;
  logic [3:0] preset_active;
  int num_errors = 0, samples_checked = 0, n_on = 0, n_off = 0, n_rst = 0;

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (rf_on_req === 1'b1) n_on++;
    if (rf_off_req === 1'b1) n_off++;
    if (sys_reset_req === 1'b1) n_rst++;
  end

  rdio_mapper #(.REPEAT_CYC(50)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remote_in(remote_in), .rf_stage_on(rf_stage_on), .alarm(alarm),
    .audio_active(audio_active), .rf_on_req(rf_on_req),
    .rf_off_req(rf_off_req), .sys_reset_req(sys_reset_req),
    .host_reset(host_reset), .remote_enabled(remote_enabled),
    .exciter_b(exciter_b), .auto_changeover(auto_changeover),
    .power_level(power_level), .preset_active(preset_active),
    .rout_o(rout_o), .rout_oe(rout_oe));
  rdio_remote_unit i_remote (.pclk(pclk), .level_req(level_req),
    .rout_o(rout_o), .rout_oe(rout_oe), .remote_in(remote_in), .pin(pin));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic cfg_in(input int i, input logic [11:0] v);
    apb(1'b1, rdio_pkg::ADDR_INCFG + 12'(4 * i), {20'h0, v});
  endtask
  task automatic set_pin(input int i, input logic v);
    @(posedge pclk);
    level_req[i] <= v;
    // Filter delay of about 204 cycles plus margin
    repeat (230) @(posedge pclk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    `CHK("power_level", 7'h64, power_level)
    `CHK("rout_oe", 16'h0000, rout_oe)
    `CHK("remote_enabled", 1'b0, remote_enabled)
    apb(1'b0, rdio_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    apb(1'b0, 12'h0c0, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    $display("test reset done");
  endtask
  task automatic t_local();
    cfg_in(0, 12'h001);
    set_pin(0, 1'b1);
    `CHK("rf_on local", 0, n_on)
    set_pin(0, 1'b0);
    $display("test local done");
  endtask
  task automatic t_rf();
    apb(1'b1, rdio_pkg::ADDR_CTRL, 32'h1);
    cfg_in(1, 12'h021);
    set_pin(0, 1'b1);
    `CHK("rf_on", 1, n_on)
    `CHK("remote on", 1'b1, remote_enabled)
    set_pin(1, 1'b1);
    `CHK("rf_off", 1, n_off)
    set_pin(1, 1'b0);
    `CHK("rf_off fall", 1, n_off)
    cfg_in(1, 12'h031);
    set_pin(1, 1'b1);
    set_pin(1, 1'b0);
    `CHK("rf_off fall off", 2, n_off)
    cfg_in(0, 12'h000);
    set_pin(0, 1'b0);
    set_pin(0, 1'b1);
    `CHK("rf_on none", 1, n_on)
    $display("test rf done");
  endtask
  task automatic t_exc_auto();
    cfg_in(2, 12'h164);
    cfg_in(3, 12'h074);
    cfg_in(4, 12'h055);
    set_pin(2, 1'b1);
    `CHK("exciter b", 1'b1, exciter_b)
    set_pin(3, 1'b1);
    `CHK("exciter rise off", 1'b1, exciter_b)
    set_pin(3, 1'b0);
    `CHK("exciter a", 1'b0, exciter_b)
    set_pin(4, 1'b1);
    `CHK("auto first", 1'b1, auto_changeover)
    set_pin(4, 1'b0);
    set_pin(4, 1'b1);
    `CHK("auto second", 1'b0, auto_changeover)
    cfg_in(4, 12'h045);
    set_pin(4, 1'b0);
    `CHK("auto fall toggle", 1'b1, auto_changeover)
    $display("test exciter done");
  endtask
  task automatic t_power();
    int n;
    apb(1'b1, rdio_pkg::ADDR_POWER, 32'h32);
    cfg_in(5, 12'h086);
    cfg_in(6, 12'h0a6);
    @(posedge pclk);
    level_req[6:5] <= 2'b11;
    n = 0;
    while (power_level === 7'h32 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) begin
      num_errors++;
      end_sim();
    end
    `CHK("first step", 7'h33, power_level)
    repeat (175) @(posedge pclk);
    `CHK("held steps", 7'h36, power_level)
    set_pin(5, 1'b0);
    set_pin(6, 1'b0);
    pw = power_level;
    repeat (100) @(posedge pclk);
    `CHK("released", pw, power_level)
    apb(1'b0, rdio_pkg::ADDR_POWER, 32'h0);
    `CHK("power reg", {25'h0, pw}, rd)
    $display("test power done");
  endtask
  task automatic t_preset_hosts();
    cfg_in(7, 12'h387);
    cfg_in(8, 12'h002);
    cfg_in(9, 12'h003);
    set_pin(7, 1'b1);
    `CHK("preset", 4'h3, preset_active)
    set_pin(8, 1'b1);
    `CHK("sys reset", 1, n_rst)
    set_pin(9, 1'b1);
    `CHK("host reset", 1'b1, host_reset)
    repeat (2000) @(posedge pclk);
    `CHK("host reset end", 1'b0, host_reset)
    $display("test preset done");
  endtask
  task automatic t_outputs();
    logic [11:0] o;
    o = rdio_pkg::ADDR_OUTCFG;
    apb(1'b1, o, 32'h001);
    apb(1'b1, o + 12'h004, 32'h101);
    apb(1'b1, o + 12'h008, 32'h033);
    apb(1'b1, o + 12'h00c, 32'h013);
    apb(1'b1, o + 12'h010, 32'h006);
    apb(1'b1, o + 12'h014, 32'h014);
    apb(1'b1, o + 12'h018, 32'h017);
    apb(1'b1, o + 12'h01c, 32'h002);
    apb(1'b1, o + 12'h024, 32'h005);
    @(posedge pclk);
    alarm <= 16'h0001;
    audio_active <= 4'h2;
    rf_stage_on <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("remote pin", 1'b0, pin[0])
    `CHK("remote inv", 1'b1, pin[1])
    `CHK("preset3 pin", 1'b0, pin[2])
    `CHK("preset1 oe", 1'b0, rout_oe[3])
    `CHK("alarm pin", 1'b0, pin[4])
    `CHK("exciter a pin", 1'b0, rout_oe[5])
    `CHK("audio pin", 1'b0, pin[6])
    `CHK("rf pin", 1'b0, pin[7])
    `CHK("auto pin", 1'b0, pin[9])
    `CHK("unused oe", 1'b0, rout_oe[8])
    // Same pin moved from remote status to a preset group member
    apb(1'b1, o, 32'h033);
    repeat (3) @(posedge pclk);
    `CHK("preset3 out0", 1'b0, pin[0])
    `CHK("preset3 out0 oe", 1'b1, rout_oe[0])
    $display("test outputs done");
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Let the input filters settle on the idle levels
    repeat (250) @(posedge pclk);
    t_reset();
    t_local();
    t_rf();
    t_exc_auto();
    t_power();
    t_preset_hosts();
    t_outputs();
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    end_sim();
  end
endmodule
